/* uhpfc_pkg.sv */
/*
  shared constants, types and serial engine functions for both ends of the
  host serial port. assumes a single 10 MHz clock in every user.
*/
package uhpfc_pkg;

  localparam int         CLK_HZ       = 10_000_000;
  localparam int         BUF_AW       = 6;
  localparam logic [6:0] BUF_DEPTH    = 7'h40;
  // cts goes high at this many free bytes or fewer, low again at the second
  localparam logic [6:0] CTS_OFF_FREE = 7'h11;
  localparam logic [6:0] CTS_ON_FREE  = 7'h22;
  localparam logic [3:0] SYNC_IDLE    = 4'hF;
  localparam logic       LINE_IDLE    = 1'b1;
  localparam logic [3:0] DATA_BITS    = 4'h8;
  localparam logic [1:0] PAR_NONE     = 2'h0;
  localparam logic [1:0] PAR_EVEN     = 2'h1;
  localparam logic [1:0] PAR_ODD      = 2'h2;
  localparam logic [1:0] PAR_MARK     = 2'h3;

  typedef enum logic {ST_IDLE, ST_BUSY} uhpfc_st_e;

  typedef struct packed {
    uhpfc_st_e   st;
    logic [15:0] cnt;
    logic [3:0]  idx;
    logic [7:0]  d;
    logic        pe;
    logic        done;
    logic        err;
  } uhpfc_rx_s;

  typedef struct packed {
    uhpfc_st_e   st;
    logic [15:0] cnt;
    logic [3:0]  left;
    logic [11:0] fr;
    logic        line;
  } uhpfc_tx_s;

  // clock cycles per bit for each baud setting
  function automatic logic [15:0] baud_div(input logic [2:0] sel);
    int rate;
    case (sel)
      3'h0:    rate = 1200;
      3'h1:    rate = 2400;
      3'h2:    rate = 4800;
      3'h3:    rate = 9600;
      3'h4:    rate = 19200;
      3'h5:    rate = 38400;
      3'h6:    rate = 57600;
      default: rate = 115200;
    endcase
    return 16'(CLK_HZ / rate);
  endfunction

  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] par);
    case (par)
      PAR_EVEN: return ^d;
      PAR_ODD:  return ~^d;
      PAR_MARK: return 1'b1;
      default:  return 1'b0;
    endcase
  endfunction

  // three flops; filtered level {3} follows only when second and third agree
  function automatic logic [3:0] sync_step(input logic [3:0] s, input logic pin);
    return {(s[1] == s[2]) ? s[2] : s[3], s[1:0], pin};
  endfunction

  // start low, 8 data lsb first, optional parity, stop high
  function automatic uhpfc_rx_s rx_step(input uhpfc_rx_s r, input logic line,
                                        input logic [15:0] div, input logic [1:0] par);
    uhpfc_rx_s  n;
    logic [3:0] stop_idx;
    n        = r;
    n.done   = 1'b0;
    n.err    = 1'b0;
    stop_idx = (par == PAR_NONE) ? 4'h9 : 4'hA;
    case (r.st)
      ST_IDLE:
      begin
        if (!line)
        begin
          n.st  = ST_BUSY;
          n.cnt = div >> 1;
          n.idx = 4'h0;
          n.pe  = 1'b0;
        end
      end
      ST_BUSY:
      begin
        if (r.cnt != 16'h0)
          n.cnt = r.cnt - 16'h1;
        else
        begin
          n.cnt = div - 16'h1;
          n.idx = r.idx + 4'h1;
          if (r.idx == 4'h0)
          begin
            // glitch shorter than half a bit: not a start
            if (line)
              n.st = ST_IDLE;
          end
          else if (r.idx <= DATA_BITS)
            n.d = {line, r.d[7:1]};
          else if (r.idx == stop_idx)
          begin
            n.st   = ST_IDLE;
            n.done = 1'b1;
            n.err  = !line || r.pe;
          end
          else
            n.pe = (line != par_bit(r.d, par));
        end
      end
      default: n.st = ST_IDLE;
    endcase
    return n;
  endfunction

  function automatic uhpfc_tx_s tx_step(input uhpfc_tx_s t, input logic start,
                                        input logic [7:0] d, input logic [15:0] div,
                                        input logic [1:0] par, input logic stop2);
    uhpfc_tx_s n;
    n = t;
    case (t.st)
      ST_IDLE:
      begin
        n.line = LINE_IDLE;
        if (start)
        begin
          n.st   = ST_BUSY;
          n.cnt  = div - 16'h1;
          n.line = 1'b0;
          n.fr   = {4'hF, d};
          if (par != PAR_NONE)
            n.fr[8] = par_bit(d, par);
          n.left = 4'h9 + {3'h0, par != PAR_NONE} + {3'h0, stop2};
        end
      end
      ST_BUSY:
      begin
        if (t.cnt != 16'h0)
          n.cnt = t.cnt - 16'h1;
        else if (t.left == 4'h0)
        begin
          n.st   = ST_IDLE;
          n.line = LINE_IDLE;
        end
        else
        begin
          n.line = t.fr[0];
          n.fr   = {1'b1, t.fr[11:1]};
          n.left = t.left - 4'h1;
          n.cnt  = div - 16'h1;
        end
      end
      default: n.st = ST_IDLE;
    endcase
    return n;
  endfunction

endpackage

/* uhpfc_if.sv */
/*
  serial pins between the module end and the host end.
  assumes both ends share sys_clk; lines are plain one-way wires.
*/
`timescale 1ns/1ps
interface uhpfc_if;
  logic din;
  logic dout;
  logic rts_n;
  logic cts_n;

  modport dev (
    input  din,
    input  rts_n,
    output dout,
    output cts_n
  );

  modport hst (
    output din,
    output rts_n,
    input  dout,
    input  cts_n
  );
endinterface

/* uhpfc_dev.sv */
/*
  module end of the host serial port: receive buffer toward the radio,
  transmit buffer from the radio, cts and rts flow control.
  assumes the radio side shows a packet's length with its first byte.
*/
`timescale 1ns/1ps
module uhpfc_dev (
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  // serial pins
  uhpfc_if.dev               pins,
  // settings
  input  wire logic [2:0]    baud_setting_cmd,
  input  wire logic [1:0]    parity_setting_cmd,
  input  wire logic          stop_bits_setting_cmd,
  input  wire logic          rts_flow_enable_cmd,
  input  wire logic          cts_flow_enable_cmd,
  // radio receive side, into the transmit buffer
  input  wire logic          rf_wr_valid,
  input  wire logic          rf_wr_first,
  input  wire logic [6:0]    rf_pkt_len,
  input  wire logic [7:0]    rf_wr_data,
  input  wire logic          rf_rx_active,
  output logic               rf_pkt_dropped,
  // radio transmit side, out of the receive buffer
  output logic               rfo_valid,
  output logic [7:0]         rfo_data,
  input  wire logic          rfo_ready,
  // status
  output logic [6:0]         rx_level,
  output logic [6:0]         tx_level,
  output logic               rx_frame_err,
  output logic               rx_overrun
);

  typedef struct packed {
    logic [3:0]                    din_s;
    logic [3:0]                    rts_s;
    uhpfc_pkg::uhpfc_rx_s          rx;
    logic [63:0][7:0]              rbuf;
    logic [uhpfc_pkg::BUF_AW-1:0]  rwp;
    logic [uhpfc_pkg::BUF_AW-1:0]  rrp;
    logic [6:0]                    rcnt;
    logic                          cts_n;
    uhpfc_pkg::uhpfc_tx_s          tx;
    logic [63:0][7:0]              tbuf;
    logic [uhpfc_pkg::BUF_AW-1:0]  twp;
    logic [uhpfc_pkg::BUF_AW-1:0]  trp;
    logic [6:0]                    tcnt;
    logic                          drop;
    logic                          dropped;
    logic                          ferr;
    logic                          ovr;
  } uhpfc_dev_s;

  uhpfc_dev_s  q;
  uhpfc_dev_s  d;
  logic [15:0] div;
  logic        rpush;
  logic        rpop;
  logic        tpush;
  logic        tpop;
  logic        tstart;
  logic        accept;
  logic [6:0]  rfree;
  logic [6:0]  tfree;

  assign div       = uhpfc_pkg::baud_div(baud_setting_cmd);
  assign rfo_valid = (q.rcnt != 7'h0) && !rf_rx_active;

  always_comb
  begin
    d         = q;
    d.dropped = 1'b0;
    d.ovr     = 1'b0;
    d.din_s   = uhpfc_pkg::sync_step(q.din_s, pins.din);
    d.rts_s   = uhpfc_pkg::sync_step(q.rts_s, pins.rts_n);

    // receive engine into the receive buffer
    d.rx   = uhpfc_pkg::rx_step(q.rx, q.din_s[3], div, parity_setting_cmd);
    d.ferr = d.rx.done && d.rx.err;
    rpush  = d.rx.done && !d.rx.err && (q.rcnt != uhpfc_pkg::BUF_DEPTH);
    if (d.rx.done && !d.rx.err && !rpush)
      d.ovr = 1'b1;
    if (rpush)
    begin
      d.rbuf[q.rwp] = d.rx.d;
      d.rwp         = q.rwp + 6'h1;
    end
    rpop = rfo_valid && rfo_ready;
    if (rpop)
      d.rrp = q.rrp + 6'h1;
    d.rcnt = q.rcnt + {6'h0, rpush} - {6'h0, rpop};

    // hysteresis keeps cts from chattering around one threshold
    rfree = uhpfc_pkg::BUF_DEPTH - d.rcnt;
    if (!cts_flow_enable_cmd)
      d.cts_n = 1'b0;
    else if (rfree <= uhpfc_pkg::CTS_OFF_FREE)
      d.cts_n = 1'b1;
    else if (rfree >= uhpfc_pkg::CTS_ON_FREE)
      d.cts_n = 1'b0;

    // radio packets into the transmit buffer, all or nothing
    tfree  = uhpfc_pkg::BUF_DEPTH - q.tcnt;
    accept = tfree >= rf_pkt_len;
    tpush  = 1'b0;
    if (rf_wr_valid && rf_wr_first)
    begin
      d.drop    = !accept;
      d.dropped = !accept;
      tpush     = accept;
    end
    else if (rf_wr_valid)
      tpush = !q.drop && (q.tcnt != uhpfc_pkg::BUF_DEPTH);
    if (tpush)
    begin
      d.tbuf[q.twp] = rf_wr_data;
      d.twp         = q.twp + 6'h1;
    end

    // a new character starts only while rts allows; the synchroniser delay
    // is the only overrun, well inside the five allowed
    tstart = (q.tcnt != 7'h0) && !(rts_flow_enable_cmd && q.rts_s[3]);
    tpop   = tstart && (q.tx.st == uhpfc_pkg::ST_IDLE);
    d.tx   = uhpfc_pkg::tx_step(q.tx, tstart, q.tbuf[q.trp], div,
                                parity_setting_cmd, stop_bits_setting_cmd);
    if (tpop)
      d.trp = q.trp + 6'h1;
    d.tcnt = q.tcnt + {6'h0, tpush} - {6'h0, tpop};
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q         <= '0;
      q.din_s   <= uhpfc_pkg::SYNC_IDLE;
      q.rts_s   <= uhpfc_pkg::SYNC_IDLE;
      q.tx.line <= uhpfc_pkg::LINE_IDLE;
    end
    else
      q <= d;
  end

  assign pins.dout      = q.tx.line;
  assign pins.cts_n     = q.cts_n;
  assign rfo_data       = q.rbuf[q.rrp];
  assign rf_pkt_dropped = q.dropped;
  assign rx_level       = q.rcnt;
  assign tx_level       = q.tcnt;
  assign rx_frame_err   = q.ferr;
  assign rx_overrun     = q.ovr;

endmodule

/* uhpfc_host.sv */
/*
  host end of the serial port: one character transmitter and receiver,
  rts driven from the user, cts honoured when asked.
  assumes the same settings as the module end.
*/
`timescale 1ns/1ps
module uhpfc_host (
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  // serial pins
  uhpfc_if.hst               pins,
  // settings
  input  wire logic [2:0]    baud_setting_cmd,
  input  wire logic [1:0]    parity_setting_cmd,
  input  wire logic          stop_bits_setting_cmd,
  input  wire logic          cts_honour,
  // send side
  input  wire logic          tx_valid,
  input  wire logic [7:0]    tx_data,
  output logic               tx_ready,
  // receive side
  input  wire logic          hold_off,
  output logic               rx_valid,
  output logic [7:0]         rx_data,
  output logic               rx_err
);

  typedef struct packed {
    logic [3:0]           dout_s;
    logic [3:0]           cts_s;
    logic                 rts_n;
    uhpfc_pkg::uhpfc_rx_s rx;
    uhpfc_pkg::uhpfc_tx_s tx;
    logic [7:0]           rdat;
    logic                 rvld;
    logic                 rerr;
  } uhpfc_host_s;

  uhpfc_host_s q;
  uhpfc_host_s d;
  logic [15:0] div;

  assign div = uhpfc_pkg::baud_div(baud_setting_cmd);
  // pausing on cts only delays the next start, never cuts a character
  assign tx_ready = (q.tx.st == uhpfc_pkg::ST_IDLE) && !(cts_honour && q.cts_s[3]);

  always_comb
  begin
    d        = q;
    d.dout_s = uhpfc_pkg::sync_step(q.dout_s, pins.dout);
    d.cts_s  = uhpfc_pkg::sync_step(q.cts_s, pins.cts_n);
    d.rts_n  = hold_off;
    d.tx     = uhpfc_pkg::tx_step(q.tx, tx_valid && tx_ready, tx_data, div,
                                  parity_setting_cmd, stop_bits_setting_cmd);
    // receiver never stalls, so characters after rts rises are still taken
    d.rx     = uhpfc_pkg::rx_step(q.rx, q.dout_s[3], div, parity_setting_cmd);
    d.rvld   = d.rx.done && !d.rx.err;
    d.rerr   = d.rx.done && d.rx.err;
    if (d.rx.done)
      d.rdat = d.rx.d;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q         <= '0;
      q.dout_s  <= uhpfc_pkg::SYNC_IDLE;
      q.cts_s   <= uhpfc_pkg::SYNC_IDLE;
      q.tx.line <= uhpfc_pkg::LINE_IDLE;
    end
    else
      q <= d;
  end

  assign pins.din   = q.tx.line;
  assign pins.rts_n = q.rts_n;
  assign rx_valid   = q.rvld;
  assign rx_data    = q.rdat;
  assign rx_err     = q.rerr;

endmodule

/* uhpfc_sva.sv */
/*
  assertions on the pins joining both ends.
  assumes the 115200 setting on both ends, 86 cycles a bit.
*/
`timescale 1ns/1ps
module uhpfc_sva (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rstn,
  // pins and settings
  input wire logic       din,
  input wire logic       dout,
  input wire logic       rts_n,
  input wire logic       cts_n,
  input wire logic       rts_flow_enable_cmd,
  input wire logic       cts_flow_enable_cmd,
  input wire logic [6:0] rx_level
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  localparam int FR_END = 86 * 9 + 43;
  logic [9:0] fr_q;
  logic [3:0] hi_q;
  logic [2:0] st_q;
  logic       dout_q;
  logic       start;
  // frame time ends mid tenth bit (parity, or stop without parity), so a low parity bit cannot fake a start
  assign start = dout_q && !dout && fr_q == 10'h000;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      fr_q   <= 10'h000;
      hi_q   <= 4'h0;
      st_q   <= 3'h0;
      dout_q <= 1'b1;
    end
    else
    begin
      dout_q <= dout;
      if (start)
        fr_q <= 10'h001;
      else if (fr_q != 10'h000)
        fr_q <= (fr_q == 10'(FR_END)) ? 10'h000 : fr_q + 10'h001;
      hi_q <= !rts_n ? 4'h0 : (hi_q == 4'hF) ? hi_q : hi_q + 4'h1;
      if (!rts_n || !rts_flow_enable_cmd)
        st_q <= 3'h0;
      else if (start && st_q != 3'h7)
        st_q <= st_q + 3'h1;
    end
  end
  property p_dout_low;  $fell(dout) |-> ##85 !dout; endproperty
  property p_dout_high; $rose(dout) |-> ##85 dout; endproperty
  property p_din_low;   $fell(din) |-> ##85 !din; endproperty
  property p_din_high;  $rose(din) |-> ##85 din; endproperty
  property p_cts_off;
    cts_flow_enable_cmd && rx_level >= 7'h2F |=> cts_n || !cts_flow_enable_cmd;
  endproperty
  property p_cts_on;    cts_flow_enable_cmd && rx_level <= 7'h1E |=> !cts_n; endproperty
  property p_cts_stay_high;
    // one pop can take the level from 31 to 30 and lower cts in the same edge
    cts_flow_enable_cmd && cts_n && rx_level > 7'h1F |=> cts_n || !cts_flow_enable_cmd;
  endproperty
  property p_cts_stay_low; !cts_n && rx_level < 7'h2E |=> !cts_n; endproperty
  property p_cts_dis;   !cts_flow_enable_cmd ##1 !cts_flow_enable_cmd |-> !cts_n; endproperty
  property p_rts_block;
    start |-> !($past(rts_flow_enable_cmd, 2) && rts_flow_enable_cmd && hi_q == 4'hF);
  endproperty
  property p_rts_five;  rts_flow_enable_cmd && rts_n |-> st_q <= 3'h5; endproperty
  a_dout_low:  assert property (p_dout_low) else $error("dout low bit too short");
  a_dout_high: assert property (p_dout_high) else $error("dout high bit too short");
  a_din_low:   assert property (p_din_low) else $error("din low bit too short");
  a_din_high:  assert property (p_din_high) else $error("din high bit too short");
  a_cts_off:   assert property (p_cts_off) else $error("cts not raised");
  a_cts_on:    assert property (p_cts_on) else $error("cts not lowered");
  a_cts_stay_high: assert property (p_cts_stay_high) else $error("cts low early");
  a_cts_stay_low: assert property (p_cts_stay_low) else $error("cts high early");
  a_cts_dis:   assert property (p_cts_dis) else $error("cts high while disabled");
  a_rts_block: assert property (p_rts_block) else $error("start while held");
  a_rts_five:  assert property (p_rts_five) else $error("too many after hold");
  c_start:     cover property (start);
  c_cts_full:  cover property (cts_n && rx_level == 7'h2F);
  c_cts_back:  cover property ($fell(cts_n));
endmodule

/* testbench.sv */
/*
  random bench: host end and module end joined by the pins.
  assumes 115200 baud throughout, a character takes about 900 cycles.
*/
`timescale 1ns/1ps
module testbench;
  logic       sys_clk;
  logic       rstn;
  logic [1:0] par;
  logic       stop2;
  logic       rts_en;
  logic       cts_en;
  logic       wv;
  logic       wf;
  logic [6:0] plen;
  logic [7:0] wd;
  logic       act;
  logic       drop;
  logic       fv;
  logic [7:0] fd;
  logic       frdy;
  logic [6:0] rlev;
  logic [6:0] tlev;
  logic       hon;
  logic       tv;
  logic [7:0] td;
  logic       trdy;
  logic       hold;
  logic       hv;
  logic [7:0] hd;
  logic       c;
  logic       ferr;
  logic       ovr;
  logic       herr;
  logic       bad = 1'b0;
  int         error_cnt = 0;
  int         checks_done = 0;
  int         n;
  int         used;
  logic [7:0] seed = 8'h45;
  logic [7:0] hq[$];
  logic [7:0] dq[$];
  uhpfc_if bus ();
  uhpfc_dev uhpfc_dev_inst (.sys_clk(sys_clk), .rstn(rstn), .pins(bus.dev),
    .baud_setting_cmd(3'h7), .parity_setting_cmd(par), .stop_bits_setting_cmd(stop2),
    .rts_flow_enable_cmd(rts_en), .cts_flow_enable_cmd(cts_en), .rf_wr_valid(wv),
    .rf_wr_first(wf), .rf_pkt_len(plen), .rf_wr_data(wd), .rf_rx_active(act),
    .rf_pkt_dropped(drop), .rfo_valid(fv), .rfo_data(fd), .rfo_ready(frdy),
    .rx_level(rlev), .tx_level(tlev), .rx_frame_err(ferr), .rx_overrun(ovr));
  uhpfc_host uhpfc_host_inst (.sys_clk(sys_clk), .rstn(rstn), .pins(bus.hst),
    .baud_setting_cmd(3'h7), .parity_setting_cmd(par), .stop_bits_setting_cmd(stop2),
    .cts_honour(hon), .tx_valid(tv), .tx_data(td), .tx_ready(trdy), .hold_off(hold),
    .rx_valid(hv), .rx_data(hd), .rx_err(herr));
  uhpfc_sva uhpfc_sva_inst (.sys_clk(sys_clk), .rstn(rstn), .din(bus.din), .dout(bus.dout),
    .rts_n(bus.rts_n), .cts_n(bus.cts_n), .rts_flow_enable_cmd(rts_en),
    .cts_flow_enable_cmd(cts_en), .rx_level(rlev));
  // matched settings never give a frame error or an overrun on either end
  always @(posedge sys_clk)
    if (ferr === 1'b1 || ovr === 1'b1 || herr === 1'b1)
      bad <= 1'b1;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // cts with its hysteresis for a buffer count
  function automatic logic cts_next(input logic q, input int lvl);
    return (lvl >= 47) ? 1'b1 : (lvl <= 30) ? 1'b0 : q;
  endfunction
  task automatic close_out();
    $display("mismatches %0d of %0d checks", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  task automatic host_send(input logic [7:0] b);
    for (int w = 0; w < 3000 && trdy !== 1'b1; w++) @(negedge sys_clk);
    tv = 1'b1;
    td = b;
    @(negedge sys_clk);
    tv = 1'b0;
  endtask
  task automatic pop();
    for (int w = 0; w < 3000 && fv !== 1'b1; w++) @(negedge sys_clk);
    chk(fd, dq.pop_front());
    frdy = 1'b1;
    @(negedge sys_clk);
    frdy = 1'b0;
  endtask
  task automatic host_get();
    for (int w = 0; w < 3000; w++)
    begin
      @(posedge sys_clk);
      #1;
      if (hv === 1'b1)
        break;
    end
    chk(8'(hv), 8'h01);
    chk(hd, hq.pop_front());
  endtask
  task automatic rf_pkt(input int len);
    logic ok;
    ok = (len <= 64 - used);
    for (int k = 0; k < len; k++)
    begin
      wv = 1'b1;
      wf = (k == 0);
      plen = 7'(len);
      wd = seed;
      if (ok)
        hq.push_back(seed);
      seed = lfsr(seed);
      @(negedge sys_clk);
      if (k == 0)
        chk(8'(drop), 8'(!ok));
    end
    wv = 1'b0;
    @(negedge sys_clk);
    if (ok)
      used += len;
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // the run needs about 6 ms
  initial
  begin
    #10_000_000;
    error_cnt++;
    close_out();
  end
  initial
  begin
    {rstn, par, stop2, rts_en, wv, wf, plen, wd, frdy, hon, tv, td, hold} = '0;
    {cts_en, act, c} = 3'h6;
    used = 0;
    cyc(8);
    rstn = 1'b1;
    cyc(4);
    chk(8'(bus.din), 8'h01);
    // radio busy, so the receive buffer only fills
    for (n = 1; n <= 47; n++)
    begin
      par = 2'(n);
      stop2 = n[2];
      host_send(seed);
      dq.push_back(seed);
      seed = lfsr(seed);
      for (int w = 0; w < 3000 && rlev !== 7'(n); w++) @(negedge sys_clk);
      cyc(2);
      c = cts_next(c, n);
      chk(8'(bus.cts_n), 8'(c));
    end
    chk(8'(fv), 8'h00);
    hon = 1'b1;
    cyc(6);
    chk(8'(trdy), 8'h00);
    cts_en = 1'b0;
    cyc(3);
    chk(8'(bus.cts_n), 8'h00);
    cts_en = 1'b1;
    cyc(3);
    chk(8'(bus.cts_n), 8'h01);
    act = 1'b0;
    for (n = 46; n >= 0; n--)
    begin
      pop();
      cyc(1);
      c = cts_next(c, n);
      chk(8'(bus.cts_n), 8'(c));
    end
    {hon, par, stop2, rts_en, hold} = 5'h0F;
    cyc(10);
    rf_pkt(40);
    rf_pkt(30);
    rf_pkt(24);
    chk(8'(tlev), 8'h40);
    cyc(2000);
    chk(8'(bus.dout), 8'h01);
    rts_en = 1'b0;
    repeat (3) host_get();
    rts_en = 1'b1;
    n = 0;
    // a design that ignores the hold would send about six here
    repeat (6000)
    begin
      @(posedge sys_clk);
      #1;
      if (hv === 1'b1)
      begin
        n++;
        chk(hd, hq.pop_front());
      end
    end
    chk(8'(n <= 5), 8'h01);
    hold = 1'b0;
    repeat (2) host_get();
    rstn = 1'b0;
    cyc(2);
    rstn = 1'b1;
    cyc(2);
    chk(8'(tlev), 8'h00);
    chk(8'(bus.dout), 8'h01);
    chk(8'(bad), 8'h00);
    close_out();
  end
endmodule
